// ==== pkg/spfa_pkg.sv ====
// package: constants and types of the spi host fifo access block
//
// Operation
// R01: rx level flag while rx count >= rx threshold; zero threshold disables it
// R02: tx level flag while tx count <= tx threshold; zero threshold disables it
// R03: tx port write pushes one, two or four bytes by access size
// R04: software puts tx payload in the lowest byte lanes
// R05: tx port write without room sets the tx overflow flag
// R06: accepted tx port write raises the tx byte count by its size
// R07: rx port read pops bytes, byte on 7:0, halfword on 15:0
// R08: rx read asking more than held completes but sets rx underflow flag
// R09: rx port read lowers the rx byte count by the bytes taken
// R10: bytes captured from the slave are pushed into the rx fifo
// R11: count word shows rx count in 31:16 and tx count in 15:0
// R12: word rx read returns four bytes, oldest in the lowest lane
package spfa_pkg;

   // ----------------------------------------------------------------
   // fifo geometry
   // ----------------------------------------------------------------
   localparam int SPFA_DEPTH = 16;
   localparam int SPFA_PTR_W = 4;
   localparam int SPFA_CNT_W = 5;
   localparam int SPFA_NB_W = 3;
   localparam int SPFA_LANES = 4;
   localparam int SPFA_HALF_W = 16;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SPFA_OFS_COUNT = 8'h14;
   localparam logic [7:0] SPFA_OFS_THRESH = 8'h1c;
   localparam logic [7:0] SPFA_OFS_TXPORT = 8'h20;
   localparam logic [7:0] SPFA_OFS_RXPORT = 8'h24;
   localparam logic [7:0] SPFA_OFS_ERRSTAT = 8'h28;

   // error and status word bit positions
   localparam int SPFA_BIT_TXOVF = 0;
   localparam int SPFA_BIT_RXUNF = 1;
   localparam int SPFA_BIT_TXLVL = 2;
   localparam int SPFA_BIT_RXLVL = 3;

   localparam logic [31:0] SPFA_THRESH_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // bus slave states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPFA_ST_IDLE = 2'b00,
      SPFA_ST_CAPT = 2'b01,
      SPFA_ST_ACK = 2'b10
   } spfa_bus_state_type;

endpackage

// ==== hdl/spfa_byte_fifo.sv ====
// byte-wide fifo memory with multi-byte push and registered pop data
`timescale 1ns/10ps
`default_nettype none
module spfa_byte_fifo (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [2:0] pushCnt,
   input wire logic [31:0] pushData,
   input wire logic [2:0] popCnt,
   output logic [31:0] popData,
   output logic [4:0] count
);
   typedef struct packed {
      logic [spfa_pkg::SPFA_DEPTH-1:0][7:0] mem;
      logic [spfa_pkg::SPFA_PTR_W-1:0] wrPtr;
      logic [spfa_pkg::SPFA_PTR_W-1:0] rdPtr;
      logic [spfa_pkg::SPFA_CNT_W-1:0] cnt;
      logic [31:0] rdData;
   } spfa_fifo_state_type;

   spfa_fifo_state_type st_reg;
   spfa_fifo_state_type st_next;
   logic [2:0] popN;

   // caller guarantees room for a push; a pop is clipped to what is held
   always_comb begin
      st_next = st_reg;
      popN = (5'(popCnt) > st_reg.cnt) ? st_reg.cnt[2:0] : popCnt;
      if (popCnt != 3'h0) begin
         st_next.rdData = 32'h0; // missing lanes read zero on underflow
      end
      for (int i = 0; i < spfa_pkg::SPFA_LANES; i++) begin
         if (3'(i) < pushCnt) begin
            st_next.mem[st_reg.wrPtr + 4'(i)] = pushData[8*i +: 8];
         end
         if (3'(i) < popN) begin
            st_next.rdData[8*i +: 8] = st_reg.mem[st_reg.rdPtr + 4'(i)]; // oldest low [R12]
         end
      end
      st_next.wrPtr = st_reg.wrPtr + 4'(pushCnt);
      st_next.rdPtr = st_reg.rdPtr + 4'(popN);
      st_next.cnt = st_reg.cnt + 5'(pushCnt) - 5'(popN);
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign popData = st_reg.rdData;
   assign count = st_reg.cnt;
endmodule
`default_nettype wire

// ==== hdl/spfa_level_trig.sv ====
// registered fifo level comparator against a programmable threshold
`timescale 1ns/10ps
`default_nettype none
module spfa_level_trig #(
   parameter bit ABOVE = 1'b1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [15:0] level,
   input wire logic [15:0] thresh,
   output logic hit
);
   typedef struct packed {
      logic hit;
   } spfa_trig_state_type;

   spfa_trig_state_type st_reg;
   spfa_trig_state_type st_next;

   // zero threshold keeps the flag low in both senses
   always_comb begin
      st_next = st_reg;
      if (ABOVE) begin
         st_next.hit = (thresh != 16'h0) && (level >= thresh);
      end else begin
         st_next.hit = (thresh != 16'h0) && (level <= thresh);
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hit = st_reg.hit;
endmodule
`default_nettype wire

// ==== hdl/spfa_fifo_access.sv ====
// wishbone register access to the spi host transmit and receive fifos
`timescale 1ns/10ps
`default_nettype none
module spfa_fifo_access (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   input wire logic [3:0] wbSel,
   input wire logic wbWe,
   input wire logic wbCyc,
   input wire logic wbStb,
   output logic wbAck,
   input wire logic txByteReq,
   output logic [7:0] txByteData,
   output logic txByteValid,
   output logic txEmpty,
   input wire logic rxByteValid,
   input wire logic [7:0] rxByteData,
   output logic rxFull,
   output logic [15:0] txCount,
   output logic [15:0] rxCount,
   output logic txLevelIrq,
   output logic rxLevelIrq,
   output logic txOverflowErr,
   output logic rxUnderflowErr
);
   // ----------------------------------------------------------------
   // word indexes and local sizes
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_COUNT = spfa_pkg::SPFA_OFS_COUNT[7:2];
   localparam logic [5:0] IDX_THRESH = spfa_pkg::SPFA_OFS_THRESH[7:2];
   localparam logic [5:0] IDX_TXPORT = spfa_pkg::SPFA_OFS_TXPORT[7:2];
   localparam logic [5:0] IDX_RXPORT = spfa_pkg::SPFA_OFS_RXPORT[7:2];
   localparam logic [5:0] IDX_ERRSTAT = spfa_pkg::SPFA_OFS_ERRSTAT[7:2];
   localparam logic [5:0] DEPTH6 = 6'(spfa_pkg::SPFA_DEPTH);
   localparam logic [4:0] DEPTH5 = 5'(spfa_pkg::SPFA_DEPTH);
   localparam int HW = spfa_pkg::SPFA_HALF_W;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      spfa_pkg::spfa_bus_state_type state;
      logic [31:0] thresh;
      logic txOvf;
      logic rxUnf;
      logic rxSel;
      logic txValid;
      logic [31:0] rdData;
   } spfa_access_state_type;

   spfa_access_state_type st_reg;
   spfa_access_state_type st_next;

   logic [2:0] selN;
   logic [5:0] wordIdx;
   logic inCapt;
   logic txWrite;
   logic rxRead;
   logic txRoom;
   logic [2:0] txPushN;
   logic [2:0] txPopN;
   logic [2:0] rxPushN;
   logic [2:0] rxPopN;
   logic [31:0] txPopData;
   logic [31:0] rxPopData;
   logic [4:0] txCnt;
   logic [4:0] rxCnt;
   logic txLvl;
   logic rxLvl;
   logic [31:0] errStat;

   // ----------------------------------------------------------------
   // fifos and level comparators
   // ----------------------------------------------------------------
   spfa_byte_fifo txFifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .pushCnt(txPushN),
      .pushData(wbDatI),
      .popCnt(txPopN),
      .popData(txPopData),
      .count(txCnt)
   );

   // captured slave bytes land in the rx fifo
   spfa_byte_fifo rxFifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .pushCnt(rxPushN),
      .pushData({24'h000000, rxByteData}), // [R10]
      .popCnt(rxPopN),
      .popData(rxPopData),
      .count(rxCnt)
   );

   spfa_level_trig #(.ABOVE(1'b0)) txTrig (
      .core_clk(core_clk),
      .nrst(nrst),
      .level(txCount),
      .thresh(st_reg.thresh[HW-1:0]),
      .hit(txLvl)
   );

   spfa_level_trig #(.ABOVE(1'b1)) rxTrig (
      .core_clk(core_clk),
      .nrst(nrst),
      .level(rxCount),
      .thresh(st_reg.thresh[2*HW-1:HW]),
      .hit(rxLvl)
   );

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   // size of a port access is the number of enabled byte lanes
   always_comb begin
      selN = 3'(wbSel[0]) + 3'(wbSel[1]) + 3'(wbSel[2]) + 3'(wbSel[3]);
      wordIdx = wbAdr[7:2];
      inCapt = (st_reg.state == spfa_pkg::SPFA_ST_CAPT);
      txWrite = inCapt && wbWe && (wordIdx == IDX_TXPORT);
      rxRead = inCapt && !wbWe && (wordIdx == IDX_RXPORT);
      txRoom = ({1'b0, txCnt} + 6'(selN)) <= DEPTH6;
   end

   // fifo strobes; a write without room pushes nothing at all
   always_comb begin
      txPushN = (txWrite && txRoom) ? selN : 3'h0; // [R03] [R06]
      txPopN = (txByteReq && (txCnt != 5'h00)) ? 3'h1 : 3'h0;
      rxPushN = (rxByteValid && !rxFull) ? 3'h1 : 3'h0; // [R10]
      rxPopN = rxRead ? selN : 3'h0; // [R07] [R09]
   end

   // status word layout
   always_comb begin
      errStat = 32'h0;
      errStat[spfa_pkg::SPFA_BIT_TXOVF] = st_reg.txOvf;
      errStat[spfa_pkg::SPFA_BIT_RXUNF] = st_reg.rxUnf;
      errStat[spfa_pkg::SPFA_BIT_TXLVL] = txLvl;
      errStat[spfa_pkg::SPFA_BIT_RXLVL] = rxLvl;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.txValid = (txPopN != 3'h0);
      case (st_reg.state)
         spfa_pkg::SPFA_ST_IDLE: begin
            st_next.rxSel = 1'b0;
            if (wbCyc && wbStb) begin
               st_next.state = spfa_pkg::SPFA_ST_CAPT;
            end
         end
         spfa_pkg::SPFA_ST_CAPT: begin
            st_next.state = spfa_pkg::SPFA_ST_ACK;
            st_next.rxSel = rxRead;
            st_next.rdData = 32'h0;
            if (!wbWe) begin
               case (wordIdx)
                  IDX_COUNT: begin
                     st_next.rdData = {11'h000, rxCnt, 11'h000, txCnt}; // [R11]
                  end
                  IDX_THRESH: begin
                     st_next.rdData = st_reg.thresh;
                  end
                  IDX_ERRSTAT: begin
                     st_next.rdData = errStat;
                  end
                  default: begin
                     st_next.rdData = 32'h0;
                  end
               endcase
            end
         end
         spfa_pkg::SPFA_ST_ACK: begin
            st_next.state = spfa_pkg::SPFA_ST_IDLE;
         end
         default: begin
            st_next.state = spfa_pkg::SPFA_ST_IDLE;
         end
      endcase

      // threshold word written per byte lane
      if (inCapt && wbWe && (wordIdx == IDX_THRESH)) begin
         for (int i = 0; i < spfa_pkg::SPFA_LANES; i++) begin
            if (wbSel[i]) begin
               st_next.thresh[8*i +: 8] = wbDatI[8*i +: 8];
            end
         end
      end

      // write-one-to-clear error bits
      if (inCapt && wbWe && (wordIdx == IDX_ERRSTAT)) begin
         if (wbSel[0] && wbDatI[spfa_pkg::SPFA_BIT_TXOVF]) begin
            st_next.txOvf = 1'b0;
         end
         if (wbSel[0] && wbDatI[spfa_pkg::SPFA_BIT_RXUNF]) begin
            st_next.rxUnf = 1'b0;
         end
      end

      // setting comes last so a new error beats a clear in the same cycle
      if (txWrite && !txRoom) begin
         st_next.txOvf = 1'b1; // [R05]
      end
      if (rxRead && (5'(selN) > rxCnt)) begin
         st_next.rxUnf = 1'b1; // [R08]
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.state <= spfa_pkg::SPFA_ST_IDLE;
         st_reg.thresh <= spfa_pkg::SPFA_THRESH_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // rx data comes straight from the fifo's read register, saving a copy
   assign wbDatO = st_reg.rxSel ? rxPopData : st_reg.rdData; // [R07] [R12]
   assign wbAck = (st_reg.state == spfa_pkg::SPFA_ST_ACK);
   assign txByteData = txPopData[7:0];
   assign txByteValid = st_reg.txValid;
   assign txEmpty = (txCnt == 5'h00);
   assign rxFull = (rxCnt == DEPTH5);
   assign txCount = 16'(txCnt); // [R11]
   assign rxCount = 16'(rxCnt); // [R11]
   assign txLevelIrq = txLvl; // [R02]
   assign rxLevelIrq = rxLvl; // [R01]
   assign txOverflowErr = st_reg.txOvf;
   assign rxUnderflowErr = st_reg.rxUnf;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   rx_level_a: assert property ( // [R01]
      @(posedge core_clk) disable iff (!nrst)
      (st_reg.thresh[2*HW-1:HW] != 16'h0) && (rxCount >= st_reg.thresh[2*HW-1:HW])
      |=> rxLevelIrq)
      else $error("rx level flag missing");

   rx_level_zero_a: assert property ( // [R01]
      @(posedge core_clk) disable iff (!nrst)
      (st_reg.thresh[2*HW-1:HW] == 16'h0) |=> !rxLevelIrq)
      else $error("rx level flag with zero threshold");

   tx_level_a: assert property ( // [R02]
      @(posedge core_clk) disable iff (!nrst)
      (st_reg.thresh[HW-1:0] != 16'h0) && (txCount <= st_reg.thresh[HW-1:0])
      |=> txLevelIrq)
      else $error("tx level flag missing");

   tx_level_off_a: assert property ( // [R02]
      @(posedge core_clk) disable iff (!nrst)
      (txCount > st_reg.thresh[HW-1:0]) |=> !txLevelIrq)
      else $error("tx level flag above threshold");

   tx_push_cnt_a: assert property ( // [R03] [R06]
      @(posedge core_clk) disable iff (!nrst)
      txWrite && txRoom && !txByteReq
      |=> txCount == $past(txCount) + 16'($past(selN)))
      else $error("tx count not raised by access size");

   tx_overflow_a: assert property ( // [R05]
      @(posedge core_clk) disable iff (!nrst)
      txWrite && !txRoom |=> txOverflowErr && (txCount <= $past(txCount)))
      else $error("tx overflow not flagged");

   rx_pop_cnt_a: assert property ( // [R09]
      @(posedge core_clk) disable iff (!nrst)
      rxRead && (5'(selN) <= rxCnt) && !rxByteValid
      |=> rxCount == $past(rxCount) - 16'($past(selN)))
      else $error("rx count not lowered by access size");

   rx_underflow_a: assert property ( // [R08]
      @(posedge core_clk) disable iff (!nrst)
      rxRead && (5'(selN) > rxCnt) |=> rxUnderflowErr ##0 wbAck)
      else $error("rx underflow not flagged or read not completed");

   rx_push_a: assert property ( // [R10]
      @(posedge core_clk) disable iff (!nrst)
      rxByteValid && !rxFull && !rxRead |=> rxCount == $past(rxCount) + 16'h0001)
      else $error("rx byte not captured");

   ack_pulse_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      wbCyc && wbStb && (st_reg.state == spfa_pkg::SPFA_ST_IDLE)
      |=> !wbAck ##1 wbAck ##1 !wbAck)
      else $error("bus answer not two cycles after request");
endmodule
`default_nettype wire

// ==== test/spfa_engine_model.sv ====
// behavioural shift engine partner: pulls tx bytes and delivers rx bytes
`timescale 1ns/10ps
`default_nettype none
module spfa_engine_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [3:0] gap,
   input wire logic txGo,
   input wire logic rxGo,
   input wire logic [7:0] rxVal,
   input wire logic txByteValid,
   input wire logic [7:0] txByteData,
   output logic txByteReq,
   output logic rxByteValid,
   output logic [7:0] rxByteData,
   output logic [31:0] txHist
);
   typedef struct packed {
      logic txPend;
      logic rxPend;
      logic [3:0] txWait;
      logic [3:0] rxWait;
      logic txReq;
      logic rxVld;
      logic [7:0] rxDat;
      logic [31:0] hist;
   } spfa_model_state_type;

   spfa_model_state_type stReg;
   spfa_model_state_type stNext;

   // ----------------------------------------------------------------
   // request timing, gap sets a slow or prompt engine
   // ----------------------------------------------------------------
   always_comb begin
      stNext = stReg;
      stNext.txReq = 1'b0;
      stNext.rxVld = 1'b0;
      // data line toggles outside a delivery so a stale byte never looks valid
      stNext.rxDat = ~stReg.rxDat;
      if (txGo) begin
         stNext.txPend = 1'b1;
         stNext.txWait = gap;
      end else if (stReg.txPend && stReg.txWait == 4'h0) begin
         stNext.txReq = 1'b1;
         stNext.txPend = 1'b0;
      end else if (stReg.txPend) begin
         stNext.txWait = stReg.txWait - 4'h1;
      end
      if (rxGo) begin
         stNext.rxPend = 1'b1;
         stNext.rxWait = gap;
      end else if (stReg.rxPend && stReg.rxWait == 4'h0) begin
         stNext.rxVld = 1'b1;
         stNext.rxDat = rxVal;
         stNext.rxPend = 1'b0;
      end else if (stReg.rxPend) begin
         stNext.rxWait = stReg.rxWait - 4'h1;
      end
      // newest byte enters at the top, so four pops rebuild a word
      if (txByteValid) begin
         stNext.hist = {txByteData, stReg.hist[31:8]};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end

   assign txByteReq = stReg.txReq;
   assign rxByteValid = stReg.rxVld;
   assign rxByteData = stReg.rxDat;
   assign txHist = stReg.hist;
endmodule
`default_nettype wire

// ==== test/spfa_fifo_access_tb.sv ====
// self-checking bench for the fifo access block over wishbone
`timescale 1ns/10ps
`default_nettype none
module spfa_fifo_access_tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDatI = 32'h0;
   logic [3:0] wbSel = 4'h0;
   logic wbWe = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic txGo = 1'b0;
   logic rxGo = 1'b0;
   logic [7:0] rxVal = 8'h00;
   logic [3:0] gap = 4'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic txByteReq;
   logic [7:0] txByteData;
   logic txByteValid;
   logic txEmpty;
   logic rxByteValid;
   logic [7:0] rxByteData;
   logic rxFull;
   logic [15:0] txCount;
   logic [15:0] rxCount;
   logic txLevelIrq;
   logic rxLevelIrq;
   logic txOverflowErr;
   logic rxUnderflowErr;
   logic [31:0] txHist;
   logic [31:0] rd;
   int error_cnt = 0;
   int n_tests = 0;

   spfa_fifo_access uut (.core_clk(core_clk), .nrst(nrst), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
      .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .txByteReq(txByteReq),
      .txByteData(txByteData), .txByteValid(txByteValid), .txEmpty(txEmpty), .rxByteValid(rxByteValid),
      .rxByteData(rxByteData), .rxFull(rxFull), .txCount(txCount), .rxCount(rxCount),
      .txLevelIrq(txLevelIrq), .rxLevelIrq(rxLevelIrq), .txOverflowErr(txOverflowErr),
      .rxUnderflowErr(rxUnderflowErr));

   spfa_engine_model model (.core_clk(core_clk), .nrst(nrst), .gap(gap), .txGo(txGo), .rxGo(rxGo),
      .rxVal(rxVal), .txByteValid(txByteValid), .txByteData(txByteData), .txByteReq(txByteReq),
      .rxByteValid(rxByteValid), .rxByteData(rxByteData), .txHist(txHist));

   // ----------------------------------------------------------------
   // clock, tasks and verdict
   // ----------------------------------------------------------------
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic single cycle; held until ack is sampled, no fixed latency assumed
   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      int k;
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatI <= dat;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wbAck !== 1'b1 && k < 20);
      rd = wbDatO;
      check(32'(k < 20), 32'h1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   // one engine transfer: tx pull or rx delivery, waits for its strobe
   task automatic engine(input logic isRx, input logic [7:0] v);
      int k;
      @(posedge core_clk);
      txGo <= !isRx;
      rxGo <= isRx;
      rxVal <= v;
      @(posedge core_clk);
      txGo <= 1'b0;
      rxGo <= 1'b0;
      k = 0;
      while ((isRx ? rxByteValid : txByteValid) !== 1'b1 && k < 40) begin
         @(posedge core_clk);
         k++;
      end
      // one more edge so the model and the counts have taken the last byte
      @(posedge core_clk);
      check(32'(k < 40), 32'h1);
   endtask

   task automatic pull(input int n);
      for (int i = 0; i < n; i++) begin
         engine(1'b0, 8'h00);
      end
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      wb(1'b0, 8'h1c, 4'hf, 32'h0);
      check(rd, 32'h0);
      check({txLevelIrq, rxLevelIrq}, 32'h0);
      wb(1'b1, 8'h1c, 4'hf, 32'h0002_0003);
      wb(1'b0, 8'h1c, 4'hf, 32'h0);
      check(rd, 32'h0002_0003);
      check(txLevelIrq, 32'h1);
      wb(1'b1, 8'h20, 4'h1, 32'h0000_00a5);
      wb(1'b1, 8'h20, 4'h3, 32'h0000_c3b2);
      wb(1'b1, 8'h20, 4'hf, 32'h7766_5544);
      wb(1'b0, 8'h14, 4'hf, 32'h0);
      check(rd, 32'h0000_0007);
      check(txLevelIrq, 32'h0);
      pull(3);
      check(txHist[31:8], 32'hc3b2a5);
      pull(1);
      repeat (2) @(posedge core_clk);
      check(txLevelIrq, 32'h1);
      pull(3);
      check(txHist, 32'h7766_5544);
      // fill to the brim, then one more byte must be refused
      for (int i = 1; i <= 4; i++) begin
         wb(1'b1, 8'h20, 4'hf, {4{8'(i)}});
      end
      check(txOverflowErr, 32'h0);
      wb(1'b1, 8'h20, 4'h1, 32'h0000_00ee);
      check(txOverflowErr, 32'h1);
      check(txCount, 32'h10);
      wb(1'b1, 8'h28, 4'h1, 32'h1);
      check(txOverflowErr, 32'h0);
      gap <= 4'h3;
      pull(16);
      check(txHist, 32'h0404_0404);
      check({txEmpty, txCount}, 32'h10000);
      gap <= 4'h0;
      for (int i = 0; i < 6; i++) begin
         engine(1'b1, 8'h11 + 8'(i));
      end
      wb(1'b0, 8'h14, 4'hf, 32'h0);
      check(rd, 32'h0006_0000);
      check(rxLevelIrq, 32'h1);
      wb(1'b0, 8'h24, 4'hf, 32'h0);
      check(rd, 32'h1413_1211);
      repeat (2) @(posedge core_clk);
      check(rxLevelIrq, 32'h1);
      wb(1'b0, 8'h24, 4'h1, 32'h0);
      check(rd[7:0], 32'h15);
      check(rxCount, 32'h1);
      // level flag trails the count by one edge
      @(posedge core_clk);
      check(rxLevelIrq, 32'h0);
      check(rxUnderflowErr, 32'h0);
      wb(1'b0, 8'h24, 4'h3, 32'h0);
      check(rd[15:0], 32'h0016);
      check(rxUnderflowErr, 32'h1);
      check(rxCount, 32'h0);
      wb(1'b0, 8'h3c, 4'hf, 32'h0);
      check(rd, 32'h0);
      // status word: overflow cleared, underflow sticky, tx level set, rx level clear
      wb(1'b0, 8'h28, 4'hf, 32'h0);
      check(rd, 32'h0000_0006);
      // fill the rx fifo; a delivery into a full fifo is dropped
      for (int i = 0; i <= 16; i++) begin
         engine(1'b1, 8'(i));
      end
      check({rxFull, rxCount}, 32'h1_0010);
      check(rxLevelIrq, 32'h1);
      // second reset in mid-run returns thresholds and counts to zero
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      wb(1'b0, 8'h14, 4'hf, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 8'h1c, 4'hf, 32'h0);
      check(rd, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
